// [hw/css_startup_seq.v]
// configuration loader and startup sequencer
`timescale 1ns/1ps
module css_startup_seq #(
    parameter WORD_W = 32
) (
    input  wire              core_clk_i,
    input  wire              sys_rst_i,
    // options
    input  wire [3:0]        done_phase_i,
    input  wire              done_pipeline_enable_i,
    input  wire [3:0]        tristate_phase_i,
    input  wire [3:0]        write_enable_phase_i,
    input  wire [3:0]        lock_wait_phase_i,
    input  wire              parallel_abort_enable_i,
    input  wire              crc_enable_i,
    input  wire              encrypt_i,
    input  wire              active_reconfig_enable_i,
    input  wire              debug_image_mode_i,
    input  wire              wide_flash_address_enable_i,
    input  wire [2:0]        flash_bus_width_i,
    input  wire              fall_edge_capture_i,
    input  wire              persist_enable_i,
    input  wire              internal_config_port_used_i,
    input  wire              test_port_disable_i,
    input  wire [1:0]        startup_clock_select_i,
    input  wire              user_startup_clock_i,
    input  wire              test_clock_source_i,
    input  wire              config_clock_tick_i,
    // pins and status
    input  wire              done_pin_i,
    input  wire              clocks_locked_i,
    input  wire              abort_seq_i,
    input  wire [3:0]        flash_data_i,
    input  wire              flash_data_fall_i,
    input  wire              test_scan_req_i,
    // configuration words
    input  wire              word_valid_i,
    input  wire [WORD_W-1:0] word_i,
    // outputs
    output reg               config_done_o,
    output reg               io_tristate_release_o,
    output reg               global_write_enable_o,
    output reg               block_ram_enable_o,
    output reg               global_high_hold_o,
    output reg               global_set_reset_o,
    output reg               config_error_o,
    output reg               config_abort_o,
    output reg               watchdog_enable_o,
    output reg  [31:0]       user_watchdog_value_o,
    output reg               load_output_valid_o,
    output reg  [31:0]       load_output_register_o,
    output reg  [1:0]        revision_select_outputs_o,
    output reg               revision_select_oe_o,
    output reg  [31:0]       user_access_register_o,
    output reg  [31:0]       user_identifier_o,
    output reg  [31:0]       flash_address_o,
    output reg  [5:0]        flash_address_bits_o,
    output reg  [7:0]        flash_read_cmd_o,
    output reg  [3:0]        flash_capture_o,
    output reg               config_pins_attached_o,
    output reg               test_scan_grant_o,
    output reg  [2:0]        startup_phase_o
);
`include "css_cfg_map.vh"

    // ==========================================================
    // pin synchronisers
    // ==========================================================
    reg [1:0] done_s;
    reg [1:0] lock_s;
    reg [3:0] abort_s;
    reg [3:0] uclk_s;
    reg [3:0] tck_s;
    always @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            done_s  <= 2'h0;
            lock_s  <= 2'h0;
            abort_s <= 4'h0;
            uclk_s  <= 4'h0;
            tck_s   <= 4'h0;
        end else begin
            done_s  <= {done_s[0], done_pin_i};
            lock_s  <= {lock_s[0], clocks_locked_i};
            abort_s <= {abort_s[2:0], abort_seq_i};
            uclk_s  <= {uclk_s[2:0], user_startup_clock_i};
            tck_s   <= {tck_s[2:0], test_clock_source_i};
        end
    end
    wire done_pin = done_s[1];
    wire locked   = lock_s[1];
    wire abort_rq = abort_s[1] & ~abort_s[2];

    // startup step from selected source; source 0 is the internal clock tick
    reg  step;
    always @* begin
        case (startup_clock_select_i)
            2'd1:    step = uclk_s[2] & ~uclk_s[3];
            2'd2:    step = tck_s[2] & ~tck_s[3];
            default: step = config_clock_tick_i;
        endcase
    end

    // ==========================================================
    // loader state machine
    // ==========================================================
    localparam [4:0] ST_SYNC  = 5'b00001;
    localparam [4:0] ST_HEAD  = 5'b00010;
    localparam [4:0] ST_DATA  = 5'b00100;
    localparam [4:0] ST_START = 5'b01000;
    localparam [4:0] ST_FAIL  = 5'b10000;

    reg  [4:0] state;
    reg  [7:0] cmd;
    reg [31:0] frame_addr;
    reg        zeros_pending;
    wire       crc_on = crc_enable_i & ~encrypt_i;
    wire [31:0] crc_val;
    wire       crc_word = (state == ST_DATA) && (cmd == `CSS_CMD_CRC);
    wire       crc_clear = (state == ST_SYNC) ||
                           (debug_image_mode_i && crc_word && word_valid_i);
    wire       restart = abort_rq & parallel_abort_enable_i;

    css_crc32 #(.W(WORD_W)) u_crc (
        .core_clk_i (core_clk_i),
        .sys_rst_i  (sys_rst_i),
        .clear_i    (crc_clear),
        .enable_i   (crc_on && word_valid_i && state != ST_SYNC && !crc_word),
        .data_i     (word_i),
        .crc_o      (crc_val)
    );

    always @(posedge core_clk_i) begin
        if (sys_rst_i || restart) begin
            state                  <= ST_SYNC;
            cmd                    <= 8'h00;
            frame_addr             <= `CSS_ZERO_WORD;
            zeros_pending          <= 1'b0;
            config_error_o         <= 1'b0;
            watchdog_enable_o      <= 1'b0;
            user_watchdog_value_o  <= `CSS_ZERO_WORD;
            user_access_register_o <= `CSS_ZERO_WORD;
            user_identifier_o      <= `CSS_USER_IDENTIFIER_DEF;
            load_output_valid_o    <= 1'b0;
            load_output_register_o <= `CSS_ZERO_WORD;
            revision_select_outputs_o <= `CSS_RS_DEF;
            revision_select_oe_o   <= 1'b1;
            flash_address_o        <= `CSS_ZERO_WORD;
        end else begin
            load_output_valid_o <= 1'b0;
            if (zeros_pending) begin
                zeros_pending          <= 1'b0;
                load_output_valid_o    <= 1'b1;
                load_output_register_o <= `CSS_ZERO_WORD;
            end
            if (word_valid_i) begin
                case (state)
                    ST_SYNC: if (word_i == `CSS_SYNC_WORD) begin
                        state         <= ST_HEAD;
                        zeros_pending <= debug_image_mode_i;
                    end
                    ST_HEAD: begin
                        cmd   <= word_i[31:24];
                        state <= (word_i[31:24] == `CSS_CMD_START) ? ST_START : ST_DATA;
                        flash_address_o <= flash_address_o + 32'h0000_0001;
                    end
                    ST_DATA: begin
                        state <= ST_HEAD;
                        if (cmd == `CSS_CMD_WATCHDOG) begin
                            watchdog_enable_o     <= 1'b1;
                            user_watchdog_value_o <= word_i;
                        end else if (cmd == `CSS_CMD_USRACC) begin
                            // timestamp packs day/month/year-2000/hour/min/sec in the image
                            user_access_register_o <= word_i;
                        end else if (cmd == `CSS_CMD_USER_IDENTIFIER) begin
                            user_identifier_o <= word_i;
                        end else if (cmd == `CSS_CMD_WARM_BOOT_START_ADDRESS) begin
                            revision_select_outputs_o <= word_i[`CSS_WB_RS_MSB:`CSS_WB_RS_LSB];
                            revision_select_oe_o <= word_i[`CSS_WB_TRI_BIT];
                        end else if (cmd == `CSS_CMD_FRAME) begin
                            frame_addr <= word_i;
                        end else if (cmd == `CSS_CMD_CRC) begin
                            if (crc_on && word_i != crc_val) begin
                                config_error_o <= 1'b1;
                                state          <= ST_FAIL;
                            end else if (debug_image_mode_i) begin
                                load_output_valid_o    <= 1'b1;
                                load_output_register_o <= frame_addr;
                            end
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    // ==========================================================
    // startup phases
    // ==========================================================
    reg  [2:0] phase;
    reg        done_pend;
    wire       at_lock  = (lock_wait_phase_i != `CSS_LCK_NO_LOCK_WAIT) &&
                          ({1'b0, phase} == lock_wait_phase_i) && !locked;
    wire       at_done  = ({1'b0, phase} == done_phase_i) && done_pipeline_enable_i &&
                          !(done_pin && done_pend);
    wire       running  = (state == ST_START) && (phase != `CSS_LAST_PHASE);
    wire       adv      = running && step && !at_lock && !at_done;
    wire       gate_step = (state == ST_START) && step;
    wire       gwe_w;
    wire       gts_w;
    wire       done_w;

    always @(posedge core_clk_i) begin
        if (sys_rst_i || restart || state != ST_START) begin
            phase     <= 3'h0;
            done_pend <= 1'b0;
        end else begin
            if (({1'b0, phase} == done_phase_i) && done_pin)
                done_pend <= 1'b1;
            if (adv)
                phase <= phase + `CSS_PHASE_ONE;
        end
    end

    css_phase_gate u_done (
        .core_clk_i (core_clk_i),
        .sys_rst_i  (sys_rst_i),
        .restart_i  (restart || state != ST_START),
        .step_i     (adv),
        .phase_i    (phase),
        .select_i   (done_phase_i),
        .done_i     (1'b0),
        .active_o   (done_w)
    );
    css_phase_gate u_gts (
        .core_clk_i (core_clk_i),
        .sys_rst_i  (sys_rst_i),
        .restart_i  (restart || state != ST_START),
        .step_i     (gate_step),
        .phase_i    (phase),
        .select_i   (tristate_phase_i),
        .done_i     (done_w),
        .active_o   (gts_w)
    );
    css_phase_gate u_gwe (
        .core_clk_i (core_clk_i),
        .sys_rst_i  (sys_rst_i),
        .restart_i  (restart || state != ST_START),
        .step_i     (gate_step),
        .phase_i    (phase),
        .select_i   (write_enable_phase_i),
        .done_i     (done_w),
        .active_o   (gwe_w)
    );

    // ==========================================================
    // registered outputs
    // ==========================================================
    always @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            config_done_o          <= 1'b0;
            io_tristate_release_o  <= 1'b0;
            global_write_enable_o  <= 1'b0;
            block_ram_enable_o     <= 1'b0;
            global_high_hold_o     <= 1'b0;
            global_set_reset_o     <= 1'b0;
            config_abort_o         <= 1'b0;
            flash_address_bits_o   <= `CSS_ADDR_NARROW;
            flash_read_cmd_o       <= `CSS_FLASH_READ_CMD;
            flash_capture_o        <= 4'h0;
            config_pins_attached_o <= 1'b1;
            test_scan_grant_o      <= 1'b0;
            startup_phase_o        <= 3'h0;
        end else begin
            config_done_o         <= done_w;
            io_tristate_release_o <= gts_w;
            global_write_enable_o <= gwe_w;
            block_ram_enable_o    <= gwe_w;
            global_high_hold_o    <= !active_reconfig_enable_i && !gwe_w;
            global_set_reset_o    <= !active_reconfig_enable_i && state != ST_START;
            config_abort_o        <= restart;
            flash_address_bits_o  <= wide_flash_address_enable_i ? `CSS_ADDR_WIDE
                                                                 : `CSS_ADDR_NARROW;
            flash_read_cmd_o      <= wide_flash_address_enable_i ? `CSS_FLASH_READ4_CMD
                                                                 : `CSS_FLASH_READ_CMD;
            case (flash_bus_width_i)
                3'd4:    flash_capture_o <= flash_data_i;
                3'd2:    flash_capture_o <= {2'b00, flash_data_i[1:0]};
                default: flash_capture_o <= {3'b000, fall_edge_capture_i ? flash_data_fall_i
                                                                          : flash_data_i[1]};
            endcase
            config_pins_attached_o <= !done_w ||
                                      (persist_enable_i && !internal_config_port_used_i);
            test_scan_grant_o     <= test_scan_req_i && !(test_port_disable_i && done_w);
            startup_phase_o       <= phase;
        end
    end
endmodule // css_startup_seq

// [hw/css_cfg_map.vh]
// constants for the configuration startup sequencer
`ifndef CSS_CFG_MAP_VH
`define CSS_CFG_MAP_VH

// phase select codes: 0..6 phases, 7 = keep (held), 8 = at done
`define CSS_SEL_W             4
`define CSS_SEL_KEEP          4'h7
`define CSS_SEL_DONE          4'h8
`define CSS_DONE_PHASE_DEF    4'h4
`define CSS_GTS_PHASE_DEF     4'h5
`define CSS_GWE_PHASE_DEF     4'h6
`define CSS_LCK_NO_LOCK_WAIT        4'hF
`define CSS_LAST_PHASE        3'h7
`define CSS_PHASE_ONE         3'h1

// config word stream
`define CSS_SYNC_WORD         32'hAA99_5566
`define CSS_USER_IDENTIFIER_DEF        32'hFFFF_FFFF
`define CSS_ZERO_WORD         32'h0000_0000
`define CSS_CRC_POLY          32'h1EDC_6F41
`define CSS_CRC_INIT          32'h0000_0000

// stream commands, top byte of a header word
`define CSS_CMD_WATCHDOG      8'h01
`define CSS_CMD_USRACC        8'h02
`define CSS_CMD_USER_IDENTIFIER        8'h03
`define CSS_CMD_WARM_BOOT_START_ADDRESS        8'h04
`define CSS_CMD_FRAME         8'h05
`define CSS_CMD_CRC           8'h06
`define CSS_CMD_START         8'h07

// warm boot start address fields
`define CSS_WB_RS_LSB         30
`define CSS_WB_RS_MSB         31
`define CSS_WB_TRI_BIT        29
`define CSS_RS_DEF            2'b00

// flash read setup
`define CSS_FLASH_READ_CMD    8'h03
`define CSS_FLASH_READ4_CMD   8'h13
`define CSS_ADDR_NARROW       6'h18
`define CSS_ADDR_WIDE         6'h20
`define CSS_CMD_BITS          6'h08

`endif

// [hw/css_crc32.v]
// running crc over one 32-bit configuration word
`timescale 1ns/1ps
module css_crc32 #(
    parameter W = 32
) (
    input  wire         core_clk_i,
    input  wire         sys_rst_i,
    input  wire         clear_i,
    input  wire         enable_i,
    input  wire [W-1:0] data_i,
    output reg  [31:0]  crc_o
);
`include "css_cfg_map.vh"
    reg     [31:0] c;
    integer        i;
    always @* begin
        c = crc_o;
        for (i = W-1; i >= 0; i = i - 1) begin
            if (c[31] ^ data_i[i])
                c = {c[30:0], 1'b0} ^ `CSS_CRC_POLY;
            else
                c = {c[30:0], 1'b0};
        end
    end
    always @(posedge core_clk_i) begin
        if (sys_rst_i || clear_i)
            crc_o <= `CSS_CRC_INIT;
        else if (enable_i)
            crc_o <= c;
    end
endmodule // css_crc32

// [hw/css_phase_gate.v]
// one startup output raised at a chosen phase
`timescale 1ns/1ps
module css_phase_gate (
    input  wire       core_clk_i,
    input  wire       sys_rst_i,
    input  wire       restart_i,
    input  wire       step_i,
    input  wire [2:0] phase_i,
    input  wire [3:0] select_i,
    input  wire       done_i,
    output reg        active_o
);
`include "css_cfg_map.vh"
    always @(posedge core_clk_i) begin
        if (sys_rst_i || restart_i)
            active_o <= 1'b0;
        else if (select_i == `CSS_SEL_DONE)
            active_o <= active_o | done_i;
        else if (select_i != `CSS_SEL_KEEP && step_i && {1'b0, phase_i} == select_i)
            active_o <= 1'b1;
    end
endmodule // css_phase_gate

// [testbench/css_startup_seq_assertions.sv]
// assertion checker for the startup sequencer
`timescale 1ns/1ps
module css_startup_seq_checker (
    input wire       core_clk_i,
    input wire       sys_rst_i,
    input wire [3:0] done_phase_i,
    input wire [3:0] tristate_phase_i,
    input wire [3:0] write_enable_phase_i,
    input wire       done_pipeline_enable_i,
    input wire       parallel_abort_enable_i,
    input wire       crc_enable_i,
    input wire       encrypt_i,
    input wire       active_reconfig_enable_i,
    input wire       test_port_disable_i,
    input wire       done_pin_i,
    input wire       config_done_o,
    input wire       io_tristate_release_o,
    input wire       global_write_enable_o,
    input wire       block_ram_enable_o,
    input wire       global_high_hold_o,
    input wire       global_set_reset_o,
    input wire       config_error_o,
    input wire       config_abort_o,
    input wire       test_scan_grant_o,
    input wire [2:0] startup_phase_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);
    // ==========================================
    // startup outputs
    property p_bram; block_ram_enable_o |-> global_write_enable_o; endproperty
    a_bram: assert property (p_bram) else $error("bram before write enable");
    property p_keep; done_phase_i == 4'h7 |-> !config_done_o; endproperty
    a_keep: assert property (p_keep) else $error("done while held");
    property p_tri_keep; tristate_phase_i == 4'h7 |-> !io_tristate_release_o; endproperty
    a_tri_keep: assert property (p_tri_keep) else $error("tristate while held");
    property p_gwe_done; write_enable_phase_i == 4'h8 && global_write_enable_o |-> config_done_o; endproperty
    a_gwe_done: assert property (p_gwe_done) else $error("gwe before done");
    property p_pipe; $rose(config_done_o) && done_pipeline_enable_i |-> $past(done_pin_i, 2); endproperty
    a_pipe: assert property (p_pipe) else $error("done without pin");
    property p_step;
        $changed(startup_phase_o) && !$past(sys_rst_i) |-> startup_phase_o == $past(startup_phase_o) + 3'h1;
    endproperty
    a_step: assert property (p_step) else $error("phase skipped");
    property p_last; startup_phase_o == 3'h7 |=> startup_phase_o == 3'h7; endproperty
    a_last: assert property (p_last) else $error("final phase left");
    // ==========================================
    // configuration side effects
    property p_abort; config_abort_o |-> parallel_abort_enable_i; endproperty
    a_abort: assert property (p_abort) else $error("abort while disabled");
    property p_hold;
        active_reconfig_enable_i && $past(active_reconfig_enable_i) && !$past(sys_rst_i)
            |-> !global_high_hold_o && !global_set_reset_o;
    endproperty
    a_hold: assert property (p_hold) else $error("hold during active reconfig");
    property p_crc_off; !crc_enable_i || encrypt_i |-> !config_error_o; endproperty
    a_crc_off: assert property (p_crc_off) else $error("crc error while off");
    property p_scan; test_port_disable_i && $past(config_done_o, 2) |-> !test_scan_grant_o; endproperty
    a_scan: assert property (p_scan) else $error("scan after done");
endmodule // css_startup_seq_checker

bind css_startup_seq css_startup_seq_checker u_chk (.*);

// [testbench/css_host_model.sv]
// configuring host model: words, done pin, lock, abort
`timescale 1ns/1ps
module css_host_model (
    input  wire        core_clk_i,
    output reg         word_valid_o,
    output reg  [31:0] word_o,
    output reg         done_pin_o,
    output reg         locked_o,
    output reg         abort_o
);
    initial begin
        {word_valid_o, done_pin_o, locked_o, abort_o} = 4'h2;
        word_o = 32'hFFFF_FFFF;
    end
    task send(input [31:0] w);
        begin
            @(negedge core_clk_i);
            word_valid_o = 1'b1;
            word_o = w;
            @(negedge core_clk_i);
            word_valid_o = 1'b0;
            word_o = ~w; // no stale word
        end
    endtask
    task pair(input [7:0] cmd, input [31:0] data);
        begin
            send({cmd, 24'h00_0000});
            send(data);
        end
    endtask
    task set_pins(input done_pin, input locked);
        {done_pin_o, locked_o} = {done_pin, locked};
    endtask
    task pulse_abort;
        begin
            abort_o = 1'b1;
            repeat (3) @(negedge core_clk_i);
            abort_o = 1'b0;
        end
    endtask
endmodule // css_host_model

// [testbench/css_startup_seq_tb.sv]
// self-checking bench for the startup sequencer
`timescale 1ns/1ps
`include "css_cfg_map.vh"
module css_startup_seq_tb;
    localparam [31:0] STAMP = {5'h11, 4'h3, 6'h00, 5'h0C, 6'h1E, 6'h2D};
    reg         core_clk_i = 1'b0;
    reg         sys_rst_i = 1'b1;
    reg  [3:0]  done_phase_i, tristate_phase_i, write_enable_phase_i, lock_wait_phase_i;
    reg         done_pipeline_enable_i, parallel_abort_enable_i, crc_enable_i, encrypt_i;
    reg         active_reconfig_enable_i, debug_image_mode_i, wide_flash_address_enable_i;
    reg  [2:0]  flash_bus_width_i;
    reg         fall_edge_capture_i, persist_enable_i, internal_config_port_used_i, test_port_disable_i;
    reg  [1:0]  startup_clock_select_i = 2'h0;
    reg         user_startup_clock_i = 1'b0, test_clock_source_i = 1'b0, config_clock_tick_i = 1'b0;
    reg  [3:0]  flash_data_i = 4'hA;
    reg         flash_data_fall_i = 1'b0, test_scan_req_i;
    wire        word_valid_i, done_pin_i, clocks_locked_i, abort_seq_i;
    wire [31:0] word_i, flash_address_o;
    wire        config_done_o, io_tristate_release_o, global_write_enable_o, block_ram_enable_o;
    wire        global_high_hold_o, global_set_reset_o, config_error_o, config_abort_o, watchdog_enable_o;
    wire [31:0] user_watchdog_value_o, load_output_register_o, user_access_register_o, user_identifier_o;
    wire        load_output_valid_o, revision_select_oe_o, config_pins_attached_o, test_scan_grant_o;
    wire [1:0]  revision_select_outputs_o;
    wire [5:0]  flash_address_bits_o;
    wire [7:0]  flash_read_cmd_o;
    wire [3:0]  flash_capture_o;
    wire [2:0]  startup_phase_o;
    integer     err_total = 0;
    integer     checks = 0;
    integer     i;

    always #5 core_clk_i = ~core_clk_i;
    // startup step on every other cycle
    always @(negedge core_clk_i) config_clock_tick_i <= ~config_clock_tick_i;

    css_startup_seq u_dut (.*);
    css_host_model u_host (.core_clk_i(core_clk_i), .word_valid_o(word_valid_i), .word_o(word_i),
        .done_pin_o(done_pin_i), .locked_o(clocks_locked_i), .abort_o(abort_seq_i));

    // ==========================================
    // tasks
    task chk(input [63:0] name, input [31:0] got, input [31:0] exp);
        begin
            checks = checks + 1;
            if (got !== exp) begin
                err_total = err_total + 1;
                $display("unexpected %0s expected %h seen %h", name, exp, got);
            end
        end
    endtask
    task wrap_up;
        begin
            if (err_total == 0 && checks > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask
    task defaults;
        begin
            done_phase_i = `CSS_DONE_PHASE_DEF;
            tristate_phase_i = `CSS_GTS_PHASE_DEF;
            write_enable_phase_i = `CSS_GWE_PHASE_DEF;
            lock_wait_phase_i = `CSS_LCK_NO_LOCK_WAIT;
            {done_pipeline_enable_i, parallel_abort_enable_i, crc_enable_i, encrypt_i} = 4'hE;
            {active_reconfig_enable_i, debug_image_mode_i, wide_flash_address_enable_i} = 3'h0;
            {fall_edge_capture_i, persist_enable_i, internal_config_port_used_i, test_port_disable_i} = 4'h0;
            flash_bus_width_i = 3'h1;
            test_scan_req_i = 1'b1;
            u_host.set_pins(1'b0, 1'b1);
        end
    endtask
    task start;
        begin
            sys_rst_i = 1'b1;
            repeat (3) @(negedge core_clk_i);
            sys_rst_i = 1'b0;
        end
    endtask
    task idle(input integer n);
        repeat (n) @(negedge core_clk_i);
    endtask
    task go;
        begin
            u_host.send(`CSS_SYNC_WORD);
            u_host.send({`CSS_CMD_START, 24'h00_0000});
            idle(40);
        end
    endtask
    task load_output_register(input [31:0] exp);
        integer     hit;
        reg  [31:0] seen;
        begin
            hit = 0;
            repeat (8) begin
                if (load_output_valid_o === 1'b1 && hit == 0) begin
                    hit = 1;
                    seen = load_output_register_o;
                end
                @(negedge core_clk_i);
            end
            chk("load_output_register_hit", hit, 1);
            chk("load_output_register", seen, exp);
        end
    endtask
    task abort_try(input exp);
        integer hit;
        begin
            hit = 0;
            fork
                u_host.pulse_abort;
                repeat (12) @(negedge core_clk_i) if (config_abort_o === 1'b1) hit = 1;
            join
            chk("abort", hit, exp);
        end
    endtask

    // ==========================================
    // tests
    initial begin
        defaults;
        start;
        chk("user_identifier", user_identifier_o, `CSS_USER_IDENTIFIER_DEF);
        chk("rs", revision_select_outputs_o, `CSS_RS_DEF);
        chk("abits", flash_address_bits_o, `CSS_ADDR_NARROW);
        chk("rdcmd", flash_read_cmd_o, `CSS_FLASH_READ_CMD);
        u_host.pair(`CSS_CMD_USER_IDENTIFIER, 32'h5555_0000);
        idle(2);
        chk("user_identifier", user_identifier_o, `CSS_USER_IDENTIFIER_DEF);
        u_host.send(`CSS_SYNC_WORD);
        u_host.pair(`CSS_CMD_USER_IDENTIFIER, 32'h1234_ABCD);
        u_host.pair(`CSS_CMD_USRACC, STAMP);
        u_host.pair(`CSS_CMD_WATCHDOG, 32'h0000_1F40);
        idle(2);
        chk("user_identifier", user_identifier_o, 32'h1234_ABCD);
        chk("usracc", user_access_register_o, STAMP);
        chk("wd_en", watchdog_enable_o, 1);
        chk("wd_val", user_watchdog_value_o, 32'h0000_1F40);
        for (i = 0; i < 4; i = i + 1) begin
            u_host.pair(`CSS_CMD_WARM_BOOT_START_ADDRESS, {i[1:0], i[0], 29'h0000_0000});
            idle(2);
            chk("rs", revision_select_outputs_o, i[1:0]);
            chk("rs_oe", revision_select_oe_o, i[0]);
        end
        u_host.pair(`CSS_CMD_CRC, 32'h0BAD_0001);
        idle(2);
        chk("crcerr", config_error_o, 1);
        u_host.pair(`CSS_CMD_USER_IDENTIFIER, 32'h0000_0000);
        idle(2);
        chk("user_identifier", user_identifier_o, 32'h1234_ABCD);
        defaults;
        parallel_abort_enable_i = 1'b0;
        wide_flash_address_enable_i = 1'b1;
        start;
        idle(2);
        chk("abits", flash_address_bits_o, `CSS_ADDR_WIDE);
        chk("rdcmd", flash_read_cmd_o, `CSS_FLASH_READ4_CMD);
        abort_try(1'b0);
        parallel_abort_enable_i = 1'b1;
        abort_try(1'b1);
        defaults;
        test_port_disable_i = 1'b1;
        start;
        go;
        chk("phase", startup_phase_o, 4);
        chk("done", config_done_o, 0);
        chk("tri", io_tristate_release_o, 0);
        u_host.set_pins(1'b1, 1'b1);
        for (i = 0; i < 30 && config_done_o !== 1'b1; i = i + 1) idle(1);
        chk("done", config_done_o, 1);
        idle(40);
        chk("phase", startup_phase_o, 7);
        chk("tri", io_tristate_release_o, 1);
        chk("gwe", global_write_enable_o, 1);
        chk("bram", block_ram_enable_o, 1);
        chk("attach", config_pins_attached_o, 0);
        chk("grant", test_scan_grant_o, 0);
        defaults;
        done_phase_i = `CSS_SEL_KEEP;
        write_enable_phase_i = `CSS_SEL_DONE;
        lock_wait_phase_i = 4'h2;
        tristate_phase_i = 4'h1;
        {active_reconfig_enable_i, persist_enable_i, fall_edge_capture_i} = 3'h7;
        u_host.set_pins(1'b1, 1'b0);
        start;
        go;
        chk("phase", startup_phase_o, 2);
        chk("hold", {global_high_hold_o, global_set_reset_o}, 0);
        u_host.set_pins(1'b1, 1'b1);
        idle(40);
        chk("phase", startup_phase_o, 7);
        chk("done", config_done_o, 0);
        chk("gwe", global_write_enable_o, 0);
        chk("bram", block_ram_enable_o, 0);
        chk("tri", io_tristate_release_o, 1);
        chk("attach", config_pins_attached_o, 1);
        chk("cap", flash_capture_o, 0);
        defaults;
        {debug_image_mode_i, encrypt_i, fall_edge_capture_i} = 3'h7;
        tristate_phase_i = `CSS_SEL_KEEP;
        flash_bus_width_i = 3'h4;
        start;
        u_host.send(`CSS_SYNC_WORD);
        load_output_register(`CSS_ZERO_WORD);
        u_host.pair(`CSS_CMD_FRAME, 32'h0000_0A40);
        u_host.pair(`CSS_CMD_CRC, 32'h0BAD_0002);
        load_output_register(32'h0000_0A40);
        chk("crcerr", config_error_o, 0);
        chk("cap", flash_capture_o, 4'hA);
        chk("faddr", flash_address_o, 2);
        wrap_up;
    end

    initial begin
        repeat (5000) @(posedge core_clk_i);
        err_total = err_total + 1;
        wrap_up;
    end
endmodule // css_startup_seq_tb
